// ### hdl/ufc_consts.vh
// Purpose: Shared constants for the UART frame control block
// Assumes: 32-bit AHB-Lite register bus, 20 MHz clock
// Notes:   Offsets are byte addresses of aligned words
`ifndef UFC_CONSTS_VH
`define UFC_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define UFC_OFS_CTRL1    8'h00
`define UFC_OFS_CTRL2    8'h04
`define UFC_OFS_CTRL3    8'h08
`define UFC_OFS_STATUS   8'h0c
`define UFC_OFS_DATA     8'h10
`define UFC_OFS_BAUD     8'h14
`define UFC_OFS_IRQST    8'h18
`define UFC_OFS_IRQCLR   8'h1c
`define UFC_OFS_IRQEN    8'h20

// ----------------------------------------
// Control one field positions
// ----------------------------------------
`define UFC_C1_EN        7
`define UFC_C1_NINE      6
`define UFC_C1_PAREN     5
`define UFC_C1_PODD      4
`define UFC_C1_STOP2     3
`define UFC_C1_BRK       2
`define UFC_C1_RX8       1
`define UFC_C1_TX8       0

// Control two / three field positions
`define UFC_C2_TXEN      7
`define UFC_C2_RXEN      6
`define UFC_C3_ONEW      0
`define UFC_C3_MODE      1

// Status field positions
`define UFC_ST_RXAV      7
`define UFC_ST_OERR      6
`define UFC_ST_FERR      5
`define UFC_ST_PERR      4
`define UFC_ST_NOISE     3
`define UFC_ST_RXIDLE    2
`define UFC_ST_TXIDLE    1
`define UFC_ST_TXEMPTY   0

// Interrupt status bits
`define UFC_IRQ_RXAV     0
`define UFC_IRQ_TXEMPTY  1
`define UFC_IRQ_TXIDLE   2
`define UFC_IRQ_ERR      3

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define UFC_RST_CTRL1    8'h00
`define UFC_RST_BAUD     8'h0f
`define UFC_BRK_BITS     13
`define UFC_OVERSAMPLE   16
`define UFC_START_HALF   8

`endif

// ### hdl/ufc_uart_frame_control.v
// Purpose: Frame format and master control of a UART with AHB-Lite registers
// Assumes: Inputs synchronous to clk; one AHB-Lite master
// Notes:   Pin enables are active low; released pin means enable high
// Contract
// - Enable low disables UART and releases both pins.
// - Enable high with mode set operates; pin roles from one-wire and enables.
// - Disabling empties data buffer and resets baud counter.
// - Disable clears enables, break, rx flags, errors; sets idle and empty flags.
// - Disabling keeps other control fields and divisor.
// - Clearing enable mid-transfer aborts all transfers immediately.
// - Nine-bit select chooses 8 or 9 data bits.
// - Nine-bit format stores ninth received bit, sends ninth transmit bit.
// - With parity the last character bit is parity, not stored.
// - Parity enable generates and checks parity; otherwise none.
// - Parity type select: 0 even, 1 odd.
// - Two-stop select: 0 one stop bit, 1 two stop bits.
// - Break drives transmit pin low at least 13 bits until cleared.
// - Receive ninth bit read-only, transmit ninth bit write-only.
// - One-wire off: shared pin only receives; on: role from enables.
`timescale 1ns/100ps
`include "ufc_consts.vh"

module ufc_uart_frame_control #(
  parameter DIV_W = 8
) (
  input  wire        clk,
  input  wire        rst_b,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hsel,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  output reg         txPinOut,
  output wire        txPinOe_b,
  input  wire        sharedPinIn,
  output reg         sharedPinOut,
  output wire        sharedPinOe_b,
  output wire        irq
);

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  reg  [7:0]  ctrl1_reg, ctrl2_reg, ctrl3_reg, baud_reg, stat_reg;
  reg  [8:0]  rxData_reg, txBuf_reg;
  reg  [9:0]  rxShift_reg;
  reg         txFull_reg;
  reg  [3:0]  irqSt_reg, irqEn_reg;
  reg  [7:0]  aAddr_reg;
  reg         aWr_reg, aRd_reg;
  wire        en     = ctrl1_reg[`UFC_C1_EN] & ctrl3_reg[`UFC_C3_MODE];
  wire        nine   = ctrl1_reg[`UFC_C1_NINE];
  wire        parEn  = ctrl1_reg[`UFC_C1_PAREN];
  wire        txEn   = ctrl2_reg[`UFC_C2_TXEN];
  wire        rxEn   = ctrl2_reg[`UFC_C2_RXEN];
  wire        oneW   = ctrl3_reg[`UFC_C3_ONEW];
  wire        wrData = aWr_reg & (aAddr_reg == `UFC_OFS_DATA);
  wire        rdData = aRd_reg & (aAddr_reg == `UFC_OFS_DATA);
  wire        sample;
  reg         rxDone, rxErrF, rxErrP, txTook;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Capture address phase; zero wait states keep the slave simple
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aAddr_reg <= 8'h00;
      aWr_reg   <= 1'b0;
      aRd_reg   <= 1'b0;
    end else begin
      aAddr_reg <= haddr;
      aWr_reg   <= hsel & hready & htrans[1] & hwrite;
      aRd_reg   <= hsel & hready & htrans[1] & ~hwrite;
    end
  end

  // Read mux, unmapped reads return zero
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      hrdata <= 32'h0000_0000;
    else if (hsel & hready & htrans[1] & ~hwrite) begin
      case (haddr)
        `UFC_OFS_CTRL1:  hrdata <= {24'h000000, ctrl1_reg[7:1], 1'b0};
        `UFC_OFS_CTRL2:  hrdata <= {24'h000000, ctrl2_reg};
        `UFC_OFS_CTRL3:  hrdata <= {24'h000000, ctrl3_reg};
        `UFC_OFS_STATUS: hrdata <= {24'h000000, stat_reg};
        `UFC_OFS_DATA:   hrdata <= {24'h000000, rxData_reg[7:0]};
        `UFC_OFS_BAUD:   hrdata <= {24'h000000, baud_reg};
        `UFC_OFS_IRQST:  hrdata <= {28'h0000000, irqSt_reg};
        `UFC_OFS_IRQEN:  hrdata <= {28'h0000000, irqEn_reg};
        default:         hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Control registers; disable clears only the documented control bits
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl1_reg <= `UFC_RST_CTRL1;
      ctrl2_reg <= 8'h00;
      ctrl3_reg <= 8'h00;
      baud_reg  <= `UFC_RST_BAUD;
      irqEn_reg <= 4'h0;
    end else begin
      if (aWr_reg) begin
        case (aAddr_reg)
          `UFC_OFS_CTRL1: ctrl1_reg <= {hwdata[7:2], ctrl1_reg[`UFC_C1_RX8], hwdata[0]};
          `UFC_OFS_CTRL2: ctrl2_reg <= hwdata[7:0];
          `UFC_OFS_CTRL3: ctrl3_reg <= {6'h00, hwdata[1:0]};
          `UFC_OFS_BAUD:  baud_reg  <= hwdata[7:0];
          `UFC_OFS_IRQEN: irqEn_reg <= hwdata[3:0];
          default:        ctrl3_reg <= ctrl3_reg;
        endcase
      end
      if (rxDone)
        ctrl1_reg[`UFC_C1_RX8] <= nine & ~parEn & rxShift_reg[8];
      if (!en) begin
        ctrl2_reg[`UFC_C2_TXEN] <= 1'b0;
        ctrl2_reg[`UFC_C2_RXEN] <= 1'b0;
        ctrl1_reg[`UFC_C1_BRK]  <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Baud enable divider
  // ----------------------------------------
  reg [DIV_W-1:0] baudCnt_reg;
  assign sample = en & (baudCnt_reg == {DIV_W{1'b0}});

  // Oversampling tick; reset to the divisor while disabled
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      baudCnt_reg <= {DIV_W{1'b0}};
    else if (!en || sample)
      baudCnt_reg <= baud_reg[DIV_W-1:0];
    else
      baudCnt_reg <= baudCnt_reg - 1'b1;
  end

  // Number of data-slot bits in a frame, parity included
  function [3:0] frameBits;
    input n;
    frameBits = n ? 4'd9 : 4'd8;
  endfunction

  // Parity of a 9-bit word limited to len bits, type from odd select
  function parityOf;
    input [8:0] d;
    input       n;
    input       odd;
    parityOf = (n ? ^d[7:0] : ^d[6:0]) ^ odd;
  endfunction

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  reg [1:0]  txSt_reg;
  reg [3:0]  txSub_reg, txBit_reg;
  reg [10:0] txSh_reg;
  reg [4:0]  brkCnt_reg;
  localparam TX_IDLE = 2'd0, TX_SEND = 2'd1, TX_BRK = 2'd2;
  localparam [4:0] BRK_END = 5'd `UFC_BRK_BITS + 5'd1;
  wire txTick = sample & (txSub_reg == 4'd0);
  wire txBusy = (txSt_reg != TX_IDLE);

  // Frame builder and break generator; break waits for the buffer to drain
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txSt_reg   <= TX_IDLE;
      txSub_reg  <= 4'd0;
      txBit_reg  <= 4'd0;
      txSh_reg   <= 11'h7ff;
      brkCnt_reg <= 5'd0;
      txPinOut   <= 1'b1;
      txTook     <= 1'b0;
    end else begin
      txTook <= 1'b0;
      if (!en || !txEn) begin
        txSt_reg <= TX_IDLE;
        txPinOut <= 1'b1;
      end else begin
        if (sample)
          txSub_reg <= txSub_reg + 4'd1;
        case (txSt_reg)
          TX_IDLE: begin
            if (txFull_reg) begin
              // Data bits, optional parity replaces last slot, stops high
              txSh_reg <= {1'b1, nine ? txBuf_reg : {1'b1, txBuf_reg[7:0]}, 1'b0};
              if (parEn && nine)
                txSh_reg[9] <= parityOf(txBuf_reg, 1'b1, ctrl1_reg[`UFC_C1_PODD]);
              else if (parEn)
                txSh_reg[8] <= parityOf(txBuf_reg, 1'b0, ctrl1_reg[`UFC_C1_PODD]);
              // Start, data slots and every stop bit get a whole bit period
              txBit_reg <= frameBits(nine) + 4'd2 + {3'd0, ctrl1_reg[`UFC_C1_STOP2]};
              txSt_reg  <= TX_SEND;
              txSub_reg <= 4'd0;
              txTook    <= 1'b1;
            end else if (ctrl1_reg[`UFC_C1_BRK]) begin
              txSt_reg   <= TX_BRK;
              brkCnt_reg <= 5'd0;
              txSub_reg  <= 4'd0;
            end
          end
          TX_SEND: if (txTick) begin
            txPinOut <= txSh_reg[0];
            txSh_reg <= {1'b1, txSh_reg[10:1]};
            if (txBit_reg == 4'd0) begin
              txSt_reg <= TX_IDLE;
              txPinOut <= 1'b1;
            end else
              txBit_reg <= txBit_reg - 4'd1;
          end
          TX_BRK: begin
            txPinOut <= 1'b0;
            // First tick falls with the pin, so one extra tick makes 13 whole bits
            if (txTick && brkCnt_reg != BRK_END)
              brkCnt_reg <= brkCnt_reg + 5'd1;
            if (brkCnt_reg == BRK_END && !ctrl1_reg[`UFC_C1_BRK]) begin
              txSt_reg <= TX_IDLE;
              txPinOut <= 1'b1;
            end
          end
          default: txSt_reg <= TX_IDLE;
        endcase
      end
    end
  end

  // Transmit holding buffer; write takes data plus ninth bit
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txBuf_reg  <= 9'h000;
      txFull_reg <= 1'b0;
    end else if (!en) begin
      txFull_reg <= 1'b0;
    end else if (wrData) begin
      txBuf_reg  <= {ctrl1_reg[`UFC_C1_TX8], hwdata[7:0]};
      txFull_reg <= 1'b1;
    end else if (txTook)
      txFull_reg <= 1'b0;
  end

  // ----------------------------------------
  // Receiver and pin roles
  // ----------------------------------------
  wire       sharedTx = oneW & txEn & ~rxEn;
  wire       rxIn     = sharedPinIn;
  reg        rxAct_reg;
  reg  [3:0] rxSub_reg, rxCnt_reg;

  assign txPinOe_b     = ~(en & txEn & ~sharedTx);
  assign sharedPinOe_b = ~(en & sharedTx);

  // Shared pin mirrors the frame when it is the transmitter
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      sharedPinOut <= 1'b1;
    else
      sharedPinOut <= txPinOut;
  end

  // Start detect, mid-bit sampling, LSB first
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rxAct_reg   <= 1'b0;
      rxSub_reg   <= 4'd0;
      rxCnt_reg   <= 4'd0;
      rxShift_reg <= 10'h000;
      rxDone      <= 1'b0;
      rxErrF      <= 1'b0;
      rxErrP      <= 1'b0;
    end else begin
      rxDone <= 1'b0;
      rxErrF <= 1'b0;
      rxErrP <= 1'b0;
      if (!en || !rxEn || sharedTx) begin
        rxAct_reg <= 1'b0;
      end else if (!rxAct_reg) begin
        if (sample && !rxIn) begin
          rxAct_reg <= 1'b1;
          rxSub_reg <= 4'd `UFC_START_HALF;
          rxCnt_reg <= frameBits(nine) + 4'd1;
        end
      end else if (sample) begin
        rxSub_reg <= rxSub_reg + 4'd1;
        if (rxSub_reg == 4'd15) begin
          rxShift_reg <= {rxIn, rxShift_reg[9:1]};
          if (rxCnt_reg == 4'd0) begin
            rxAct_reg <= 1'b0;
            rxDone    <= 1'b1;
            rxErrF    <= ~rxIn;  // Stop bit must be high
            rxErrP    <= parEn & (^rxShift_reg[9:1] ^ ctrl1_reg[`UFC_C1_PODD]) &
                         (nine | 1'b1);
          end else
            rxCnt_reg <= rxCnt_reg - 4'd1;
        end
      end
    end
  end

  // Align received data; 8-bit frames sit one place higher in the shifter
  wire [8:0] rxWord = nine ? rxShift_reg[8:0] : {1'b0, rxShift_reg[8:1]};

  // Receive data and status; hardware set wins over software clear
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rxData_reg <= 9'h000;
      stat_reg   <= 8'h07;
    end else if (!en) begin
      stat_reg <= 8'h07;
    end else begin
      stat_reg[`UFC_ST_TXEMPTY] <= ~txFull_reg;
      stat_reg[`UFC_ST_TXIDLE]  <= ~txFull_reg & ~txBusy;
      stat_reg[`UFC_ST_RXIDLE]  <= ~rxAct_reg;
      if (rdData)
        stat_reg[`UFC_ST_RXAV] <= 1'b0;
      if (rxDone) begin
        rxData_reg <= {1'b0, parEn & ~nine ? {1'b0, rxWord[6:0]} : rxWord[7:0]};
        stat_reg[`UFC_ST_RXAV] <= 1'b1;
        stat_reg[`UFC_ST_OERR] <= stat_reg[`UFC_ST_OERR] | (stat_reg[`UFC_ST_RXAV] & ~rdData);
        stat_reg[`UFC_ST_FERR] <= rxErrF;
        stat_reg[`UFC_ST_PERR] <= rxErrP;
      end
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  wire [3:0] irqEv = {rxErrF | rxErrP, ~txBusy & ~txFull_reg & txEn, txTook, rxDone};
  wire [3:0] irqClr = (aWr_reg && aAddr_reg == `UFC_OFS_IRQCLR) ? hwdata[3:0] : 4'h0;

  // Sticky events, set beats clear in the same cycle
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      irqSt_reg <= 4'h0;
    else
      irqSt_reg <= (irqSt_reg & ~irqClr) | (en ? irqEv : 4'h0);
  end

  assign irq = |(irqSt_reg & irqEn_reg);

endmodule // ufc_uart_frame_control

// ### testbench/ufc_line_peer.sv
// Purpose: Remote serial peer on the line, bit period in clk cycles
// Assumes: Idle-high lines, peer output idles released (high)
// Notes:   grab leaves got unknown when no start bit shows up
`timescale 1ns/100ps
module ufc_line_peer #(
  parameter int BIT = 16
) (
  input  wire logic clk,
  input  wire logic line,
  output logic      rxLine
);
  logic [31:0] got;
  initial rxLine = 1'b1;
  // Sample mid-bit from the start edge; got[0] is the start bit
  task automatic grab(input int n);
    int k;
    got = 32'hffffffff;
    for (k = 0; k < 4000 && line !== 1'b0; k++) @(posedge clk);
    if (line !== 1'b0) got = 'x;
    else begin
      repeat (BIT / 2) @(posedge clk);
      for (k = 0; k < n; k++) begin
        got[k] = line;
        repeat (BIT) @(posedge clk);
      end
    end
  endtask
  // Send n bits LSB first, then release the line high
  task automatic send(input logic [31:0] s, input int n);
    int k;
    for (k = 0; k < n; k++) begin
      @(posedge clk);
      rxLine <= s[k];
      repeat (BIT - 1) @(posedge clk);
    end
    @(posedge clk);
    rxLine <= 1'b1;
  endtask
endmodule // ufc_line_peer

// ### testbench/ufc_uart_frame_control_sva.sv
// Purpose: Port-level checks of enable, pin roles and register retention
// Assumes: Zero-wait slave, writes land at the end of the data phase
// Notes:   Control fields are shadowed from completed bus writes
`timescale 1ns/100ps
module ufc_frame_chk (
  input wire        clk,
  input wire        rst_b,
  input wire [7:0]  haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hsel,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  input wire        txPinOe_b,
  input wire        sharedPinOe_b
);
  logic       dw, dr;
  logic [7:0] da, c1, c2, c3, bd;
  wire        run = c1[7] && c3[1];
  // Shadow registers; a disabled UART drops both enables
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dw <= 1'b0; dr <= 1'b0; da <= 8'h00;
      c1 <= 8'h00; c2 <= 8'h00; c3 <= 8'h00; bd <= 8'h0f;
    end else begin
      dw <= hsel && hready && htrans[1] && hwrite;
      dr <= hsel && hready && htrans[1] && !hwrite;
      da <= haddr;
      if (dw && da == 8'h00) c1 <= hwdata[7:0];
      if (dw && da == 8'h04) c2 <= hwdata[7:0];
      if (dw && da == 8'h08) c3 <= hwdata[7:0];
      if (dw && da == 8'h14) bd <= hwdata[7:0];
      if (!run) c2 <= 8'h00;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_off_released: assert property (!c1[7] |-> txPinOe_b && sharedPinOe_b)
    else $error("pin driven while disabled");
  chk_tx_drive: assert property (run && !c3[0] && c2[7] |-> !txPinOe_b)
    else $error("tx pin not driven");
  chk_wire_rxonly: assert property (!c3[0] || (c2[7] && c2[6]) |-> sharedPinOe_b)
    else $error("shared pin driven as receiver");
  chk_wire_drive: assert property (run && c3[0] && c2[7] && !c2[6] |-> !sharedPinOe_b)
    else $error("shared pin not driven");
  chk_bus_okay: assert property (dw || dr |-> hreadyout && !hresp)
    else $error("bus response not okay");
  chk_ctrl_keep: assert property (dr && da == 8'h00 |-> hrdata[7:3] == c1[7:3] && !hrdata[0])
    else $error("control readback wrong");
  chk_baud_keep: assert property (dr && da == 8'h14 |-> hrdata[7:0] == bd)
    else $error("divisor readback wrong");
  chk_off_status: assert property (dr && da == 8'h0c && !$past(c1[7]) |-> hrdata[7:0] == 8'h07)
    else $error("status wrong while disabled");
  cover property (dr && da == 8'h0c && !c1[7]);
  cover property (run && c3[0] && c2[7] && !c2[6]);
  cover property ($fell(c1[7]) && c2[7]);
endmodule // ufc_frame_chk
bind ufc_uart_frame_control ufc_frame_chk i_chk (.clk, .rst_b, .haddr, .htrans, .hwrite, .hwdata, .hsel, .hready,
  .hrdata, .hreadyout, .hresp, .txPinOe_b, .sharedPinOe_b);

// ### testbench/tb.sv
// Purpose: Self-checking bench for frame format and enable control
// Assumes: Divisor 0, so one bit is 16 clk cycles
// Notes:   Released lines read high through pull-ups
`timescale 1ns/100ps
module tb;
  typedef struct packed {logic [3:0] c; logic [7:0] d; logic t8; logic [7:0] r;} ufc_row_t;
  logic        clk, rst_b, hwrite;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [31:0] hwdata, rv, s, e, m;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, txPinOut, txPinOe_b, sharedPinOut, sharedPinOe_b, irq, peerRx;
  wire         txLine = txPinOe_b ? 1'b1 : txPinOut;
  wire         shLine = (sharedPinOe_b | sharedPinOut) & peerRx;  // Shared wire, pulled up
  int          errors, tests_run, n, k;
  // Format {nine,parity,odd,two stop}, data, ninth bit, expected rx data
  ufc_row_t rows [6] = '{'{4'h0, 8'h5a, 1'b0, 8'h5a}, '{4'h4, 8'h3c, 1'b0, 8'h3c}, '{4'h6, 8'h81, 1'b0, 8'h01},
                         '{4'h9, 8'hc3, 1'b1, 8'hc3}, '{4'hc, 8'h0f, 1'b1, 8'h0f}, '{4'hf, 8'hf0, 1'b0, 8'hf0}};
  ufc_uart_frame_control #(.DIV_W(8)) i_dut (.clk(clk), .rst_b(rst_b), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hsel(1'b1), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .txPinOut(txPinOut), .txPinOe_b(txPinOe_b), .sharedPinIn(shLine),
    .sharedPinOut(sharedPinOut), .sharedPinOe_b(sharedPinOe_b), .irq(irq));
  ufc_line_peer #(.BIT(16)) i_peer (.clk(clk), .line(txLine), .rxLine(peerRx));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic give_verdict();
    $display("compares %0d, wrong %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] x, input string t);
    tests_run++;
    if (g !== x) begin
      errors++;
      $display("wrong value at %0t: %s", $time, t);
    end
  endtask
  task automatic hwait();
    int j;
    @(posedge clk);
    for (j = 0; hreadyout !== 1'b1; j++) begin
      if (j == 50) begin errors++; give_verdict(); end
      @(posedge clk);
    end
  endtask
  // One single transfer; read data kept in rv
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    haddr <= a; hwrite <= w; htrans <= 2'h2;
    hwait();
    htrans <= 2'h0; hwdata <= d;
    hwait();
    rv = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d); bus(1'b1, a, d); endtask
  task automatic rr(input logic [7:0] a); bus(1'b0, a, 32'h0); endtask
  task automatic waitl(input logic v);
    for (k = 0; k < 500; k++) begin
      if (txLine === v) return;
      @(posedge clk);
    end
    errors++; give_verdict();
  endtask
  task automatic poll();
    for (k = 0; k < 400; k++) begin
      rr(8'h0c);
      if (rv[7] === 1'b1) return;
    end
    errors++; give_verdict();
  endtask
  task automatic seeirq(input logic v); #1; cmp(irq, v, "irq level"); endtask
  // Expected frame: start, data LSB first, parity, stops; returns its length
  function automatic int mk(input logic [3:0] c, input logic [7:0] d, input logic t8, output logic [31:0] f);
    logic [8:0] v; logic p; int i, nb;
    v = {t8, d}; nb = c[3] ? 9 : 8; p = c[1]; f = 32'hffffffff; f[0] = 1'b0;
    for (i = 0; i < nb - 1; i++) p ^= v[i];
    if (c[2]) v[nb-1] = p;
    for (i = 0; i < nb; i++) f[i+1] = v[i];
    return 2 + nb + c[0];
  endfunction
  initial begin clk = 1'b0; forever #25 clk = ~clk; end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_b = 1'b0; haddr = 8'h00; htrans = 2'h0; hwrite = 1'b0; hwdata = 32'h0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rr(8'h00); cmp(rv, 32'h00, "ctrl reset");
    rr(8'h0c); cmp(rv, 32'h07, "status reset");
    rr(8'h14); cmp(rv, 32'h0f, "divisor reset");
    rr(8'h40); cmp(rv, 32'h00, "unmapped read");
    seeirq(1'b0);
    wr(8'h14, 32'h0); wr(8'h08, 32'h2);
    $display("reset test finished");
    foreach (rows[i]) begin
      wr(8'h00, {1'b1, rows[i].c, 2'b00, rows[i].t8});
      wr(8'h04, 32'hc0);
      n = mk(rows[i].c, rows[i].d, rows[i].t8, s);
      k = mk(rows[i].c, ~rows[i].d, rows[i].t8, e);
      e = (e << n) | (s & ~(32'hffffffff << n));
      m = ~(32'hffffffff << (2 * n + 1));
      fork i_peer.grab(2 * n + 1); begin wr(8'h10, rows[i].d); wr(8'h10, ~rows[i].d); end join
      cmp(i_peer.got & m, e & m, "tx frames");
      i_peer.send(s, n - rows[i].c[0]);
      poll();
      cmp(rv & 32'hf0, 32'h80, "rx status");
      m = (rows[i].c[3] || !rows[i].c[2]) ? 32'hff : 32'h7f;
      rr(8'h10); cmp(rv & m, rows[i].r & m, "rx data");
      rr(8'h00);
      if (rows[i].c[3] && !rows[i].c[2]) cmp(rv[1], rows[i].t8, "rx ninth");
      $display("row %0d finished", i);
    end
    wr(8'h00, 32'ha0);
    n = mk(4'h4, 8'h3c, 1'b0, s);
    i_peer.send(s ^ 32'h100, n);
    poll();
    cmp(rv & 32'hf0, 32'h90, "parity error");
    rr(8'h10);
    wr(8'h20, 32'h1); seeirq(1'b1);
    wr(8'h20, 32'h0); seeirq(1'b0);
    wr(8'h20, 32'h1); wr(8'h1c, 32'h1); seeirq(1'b0);
    rr(8'h18); cmp(rv[0], 1'b0, "irq cleared");
    wr(8'h08, 32'h3); wr(8'h04, 32'h80); wr(8'h10, 32'h00);
    repeat (40) @(posedge clk);
    cmp(shLine, 1'b0, "one-wire tx");
    repeat (200) @(posedge clk);
    wr(8'h04, 32'hc0); wr(8'h08, 32'h2);
    $display("parity, irq and wire tests finished");
    wr(8'h00, 32'h84);
    waitl(1'b0);
    wr(8'h00, 32'h80);
    repeat (200) @(posedge clk);
    cmp(txLine, 1'b0, "break too short");
    waitl(1'b1);
    $display("break test finished");
    wr(8'h00, 32'hf8); wr(8'h10, 32'h11); wr(8'h10, 32'h22);
    repeat (40) @(posedge clk);
    wr(8'h00, 32'h78);
    rr(8'h0c); cmp(rv, 32'h07, "status after abort");
    rr(8'h04); cmp(rv, 32'h00, "enables after abort");
    rr(8'h00); cmp(rv & 32'hf9, 32'h78, "ctrl kept");
    rr(8'h14); cmp(rv, 32'h00, "divisor kept");
    wr(8'h00, 32'hf8); wr(8'h04, 32'hc0);
    n = mk(4'hf, 8'h33, 1'b0, s);
    m = ~(32'hffffffff << (n + 1));
    fork i_peer.grab(n + 1); wr(8'h10, 32'h33); join
    cmp(i_peer.got & m, s & m, "clean restart");
    $display("disable test finished");
    give_verdict();
  end
endmodule // tb
